//--- hw/dmsf_pkg.sv
package dmsf_pkg;
  // =========================================================
  // bus geometry and register map (byte addresses)
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] ACC0_LO_OFS = 8'h08;
  localparam logic [7:0] ACC0_GD_OFS = 8'h0C;
  localparam logic [7:0] ACC1_LO_OFS = 8'h10;
  localparam logic [7:0] ACC1_GD_OFS = 8'h14;
  localparam logic [1:0] REGWIN_PAGE = 2'h1;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_UNINT = 2;
  localparam int ST_FLAG_LSB = 4;
  // =========================================================
  // datapath widths
  localparam int ACC_W = 36;
  localparam int REG_W = 16;
  localparam int AUC_W = 7;
  localparam int CNT_W = 8;
  localparam int DP_W = 11;
  localparam int SHORT_W = 9;
  localparam int OFFS_W = 5;
  // =========================================================
  // operation codes
  localparam logic [3:0] OP_LONG = 4'h0;
  localparam logic [3:0] OP_SHORT = 4'h1;
  localparam logic [3:0] OP_ACC_RD = 4'h2;
  localparam logic [3:0] OP_ACC_WR = 4'h3;
  localparam logic [3:0] OP_LOAD = 4'h4;
  localparam logic [3:0] OP_STORE = 4'h5;
  localparam logic [3:0] OP_SWAP = 4'h6;
  localparam logic [3:0] OP_DLOAD = 4'h7;
  localparam logic [3:0] OP_DSTORE = 4'h8;
  localparam logic [3:0] OP_PUSH = 4'h9;
  localparam logic [3:0] OP_POP = 4'hA;
  localparam logic [3:0] OP_SPECIAL = 4'hB;
  // register indices; 0..3 are the address pointers
  localparam logic [3:0] RI_RB = 4'h4;
  localparam logic [3:0] RI_RE = 4'h5;
  localparam logic [3:0] RI_J = 4'h6;
  localparam logic [3:0] RI_K = 4'h7;
  localparam logic [3:0] RI_X = 4'h8;
  localparam logic [3:0] RI_YH = 4'h9;
  localparam logic [3:0] RI_YL = 4'hA;
  localparam logic [3:0] RI_AUC = 4'hB;
  localparam logic [3:0] RI_C0 = 4'hC;
  localparam logic [3:0] RI_C1 = 4'hD;
  localparam logic [3:0] RI_C2 = 4'hE;
  localparam logic [3:0] RI_DP = 4'hF;
  // arithmetic control bits (reset value 0 turns both features on)
  localparam int AUC_ALIGN_LSB = 0;
  localparam int AUC_ZKEEP = 5;
  localparam int AUC_CLIPOFF = 6;
  // condition modes and test bases
  localparam logic [1:0] CM_ALWAYS = 2'h0;
  localparam logic [1:0] CM_IFC = 2'h2;
  localparam logic [2:0] TB_TRUE = 3'h0;
  localparam logic [2:0] TB_MI = 3'h1;
  localparam logic [2:0] TB_EQ = 3'h2;
  localparam logic [2:0] TB_LE = 3'h3;
  localparam logic [2:0] TB_LVS = 3'h4;
  localparam logic [2:0] TB_C0LT = 3'h5;
  localparam logic [2:0] TB_C1LT = 3'h6;
  // special ops
  localparam logic [3:0] SOP_SHR1 = 4'h0;
  localparam logic [3:0] SOP_SHR4 = 4'h1;
  localparam logic [3:0] SOP_SHR8 = 4'h2;
  localparam logic [3:0] SOP_SHR16 = 4'h3;
  localparam logic [3:0] SOP_COPY = 4'h4;
  localparam logic [3:0] SOP_NEG = 4'h5;
  localparam logic [3:0] SOP_NOT = 4'h6;
  localparam logic [3:0] SOP_RND = 4'h7;
  localparam logic [3:0] SOP_INCH = 4'h8;
  localparam logic [3:0] SOP_INC = 4'h9;
  localparam logic [3:0] SOP_LDY = 4'hA;
  localparam logic [3:0] SOP_LDP = 4'hB;
  localparam logic [4:0] SH_A = 5'h01;
  localparam logic [4:0] SH_B = 5'h04;
  localparam logic [4:0] SH_C = 5'h08;
  localparam logic [4:0] SH_D = 5'h10;
  // arithmetic constants
  localparam logic [35:0] RND_BIAS = 36'h000008000;
  localparam logic [35:0] INCH_ADD = 36'h000010000;
  localparam logic [35:0] INC_ADD = 36'h000000001;
  localparam logic [15:0] CLIP_POS_HI = 16'h7FFF;
  localparam logic [15:0] CLIP_NEG_HI = 16'h8000;
  localparam logic [15:0] CLIP_POS_LO = 16'hFFFF;
  localparam logic [15:0] CLIP_NEG_LO = 16'h0000;

  typedef struct packed {
    logic [3:0] opc;
    logic [3:0] rsel;
    logic [1:0] cmode;
    logic [3:0] tsel;
    logic in_cache;
    logic spare;
    logic [3:0] sop;
    logic dst;
    logic src;
    logic low;
    logic [1:0] ptr;
    logic [1:0] pmod;
    logic [4:0] offs;
  } dmsf_cmd_type;

  typedef struct packed {
    logic neg;
    logic zero;
    logic ovf;
  } dmsf_flags_type;

  typedef enum logic [1:0] {ST_IDLE, ST_SECOND, ST_POP_RD, ST_POP_LD} dmsf_state_type;
endpackage

//--- hw/dmsf_unit.sv
`timescale 1ns/10ps
// What this block does
// - long literal load refused when flagged as inside the cache loop
// - short literal fills low 9 bits; zero-extend, but sign-extend both step registers
// - short literal completes in one cycle and is allowed in the cache
// - short literal keeps only the low 9 bits of its field
// - accumulator half read gives bits 31-16 or 15-0, clipped when enabled
// - half write loads 16 bits; high write may zero low half; guards copy bit 31
// - swap loads memory word into register, writes old register back there
// - direct address joins 11 page-base bits with 5 offset bits
// - push writes at pointer, then increments pointer
// - pop decrements pointer then loads; no interrupt accepted in between
// - special functions take one cycle, one word, allowed in the cache
// - conditional special function tests a flag or its complement
// - counted form bumps counter one always; snapshot takes it when run
// - counted form never bumps counter zero; counter one test uses old value
// - right shifts by 1, 4, 8, 16 keep the sign of 36 bits
// - left shifts move low 32 bits, zero fill, guards from new bit 31
// - copy, negate and invert the full 36-bit accumulator
// - round to 20 bits in 35-16, low 16 bits forced to zero
// - high increment adds 0x00010000 and clears low half
// - full increment adds 0x00000001
// - y or product moves 32 bits, sign-extended into guards; product aligned
// - narrow signed registers read sign-extended, unsigned zero-extended
module dmsf_unit #(
  parameter int AW = 16
) (
  input logic mclk_in,
  input logic rst_n_in,
  input logic [dmsf_pkg::BUS_AW-1:0] avs_address_in,
  input logic avs_read_in,
  input logic avs_write_in,
  input logic [dmsf_pkg::BUS_DW-1:0] avs_writedata_in,
  output logic [dmsf_pkg::BUS_DW-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input logic [31:0] product_in,
  input logic bmu_valid_in,
  input logic bmu_neg_in,
  input logic bmu_zero_in,
  output logic uninterruptible_out
);
  import dmsf_pkg::*;

  dmsf_state_type state_q;
  dmsf_cmd_type cmd_q;
  dmsf_cmd_type cur;
  dmsf_flags_type flags_q;
  logic [REG_W-1:0] regs_q [16];
  logic [ACC_W-1:0] acc_q [2];
  logic refused_q;
  logic rd_pend_q;
  logic [BUS_DW-1:0] rd_mux;
  logic [BUS_DW-1:0] rd_mux_q;
  logic start, go1, one_cyc, refuse, fin, exec;
  logic sf_run, counted, clip_on_overflow, low_half_zeroing;
  logic [3:0] ptr_idx;
  logic [AW-1:0] mem_addr;
  logic mem_we;
  logic [REG_W-1:0] mem_wdata, mem_rd;
  logic wr_en;
  logic [REG_W-1:0] wr_val;
  logic acc_we;
  logic [ACC_W-1:0] acc_new;

  // =========================================================
  // helper functions
  // store a register value in its architected width
  function automatic logic [REG_W-1:0] ext_reg(input logic [3:0] i, input logic [REG_W-1:0] v);
    case (i)
      RI_AUC: ext_reg = {{(REG_W-AUC_W){1'b0}}, v[AUC_W-1:0]};
      RI_C0, RI_C1, RI_C2: ext_reg = {{(REG_W-CNT_W){v[CNT_W-1]}}, v[CNT_W-1:0]};
      RI_DP: ext_reg = {{(REG_W-DP_W){1'b0}}, v[DP_W-1:0]};
      default: ext_reg = v;
    endcase
  endfunction

  // only the low nine literal bits survive, whatever the field held
  function automatic logic [REG_W-1:0] short_ext(input logic [3:0] i,
                                                  input logic [SHORT_W-1:0] lit);
    if (i == RI_J || i == RI_K) begin
      short_ext = {{(REG_W-SHORT_W){lit[SHORT_W-1]}}, lit};
    end else begin
      short_ext = {{(REG_W-SHORT_W){1'b0}}, lit};
    end
  endfunction

  // half read with optional limiting when guard bits disagree with bit 31
  function automatic logic [REG_W-1:0] half_rd(input logic [ACC_W-1:0] a, input logic low,
                                                input logic clip);
    logic ovf;
    ovf = (a[35:31] != 5'h00) && (a[35:31] != 5'h1F);
    if (clip && ovf) begin
      if (low) begin
        half_rd = a[35] ? CLIP_NEG_LO : CLIP_POS_LO;
      end else begin
        half_rd = a[35] ? CLIP_NEG_HI : CLIP_POS_HI;
      end
    end else begin
      half_rd = low ? a[15:0] : a[31:16];
    end
  endfunction

  function automatic logic [REG_W-1:0] post_mod(input logic [REG_W-1:0] p, input logic [1:0] m,
                                                 input logic [REG_W-1:0] j);
    case (m)
      2'h1: post_mod = p + 16'h0001;
      2'h2: post_mod = p - 16'h0001;
      2'h3: post_mod = p + j;
      default: post_mod = p;
    endcase
  endfunction

  // flag test; low bit of the selector picks the complement
  function automatic logic cond_ok(input logic [3:0] t, input dmsf_flags_type f,
                                   input logic [REG_W-1:0] c0, input logic [REG_W-1:0] c1);
    logic b;
    case (t[3:1])
      TB_TRUE: b = 1'b1;
      TB_MI: b = f.neg;
      TB_EQ: b = f.zero;
      TB_LE: b = f.neg | f.zero;
      TB_LVS: b = f.ovf;
      TB_C0LT: b = c0[CNT_W-1];
      TB_C1LT: b = c1[CNT_W-1];
      default: b = 1'b0;
    endcase
    cond_ok = b ^ t[0];
  endfunction

  // special function arithmetic, all in one cycle
  function automatic logic [ACC_W-1:0] sf_calc(input logic [3:0] op, input logic [ACC_W-1:0] s,
                                                input logic [31:0] y, input logic [31:0] p,
                                                input logic [1:0] align);
    logic [4:0] sh;
    logic [31:0] t;
    logic [31:0] pa;
    logic [ACC_W-1:0] r;
    case (op[1:0])
      2'h0: sh = SH_A;
      2'h1: sh = SH_B;
      2'h2: sh = SH_C;
      default: sh = SH_D;
    endcase
    case (align)
      2'h1: pa = 32'($signed(p) >>> 2);
      2'h2: pa = p << 2;
      default: pa = p;
    endcase
    t = s[31:0] << sh;
    case (op)
      SOP_SHR1, SOP_SHR4, SOP_SHR8, SOP_SHR16: r = ACC_W'($signed(s) >>> sh);
      SOP_COPY: r = s;
      SOP_NEG: r = ACC_W'(-s);
      SOP_NOT: r = ~s;
      SOP_RND: begin
        r = s + RND_BIAS;
        r = {r[35:16], 16'h0000};
      end
      SOP_INCH: begin
        r = s + INCH_ADD;
        r = {r[35:16], 16'h0000};
      end
      SOP_INC: r = s + INC_ADD;
      SOP_LDY: r = {{4{y[31]}}, y};
      SOP_LDP: r = {{4{pa[31]}}, pa};
      default: r = {{4{t[31]}}, t};
    endcase
    sf_calc = r;
  endfunction

  // =========================================================
  // command decode
  // the master holds the command word, so idle decodes it straight off the bus
  assign cur = (state_q == ST_IDLE) ? dmsf_cmd_type'(avs_writedata_in) : cmd_q;
  assign start = avs_write_in && (avs_address_in == CMD_OFS);
  assign go1 = (state_q == ST_IDLE) && start;
  assign refuse = (cur.opc == OP_LONG && cur.in_cache)
      || (cur.opc == OP_SHORT && cur.rsel > RI_K) || (cur.opc > OP_SPECIAL);
  assign one_cyc = refuse || cur.opc == OP_SHORT || cur.opc == OP_SPECIAL;
  assign fin = (go1 && one_cyc) || state_q == ST_SECOND || state_q == ST_POP_LD;
  assign exec = fin && !refuse;
  assign clip_on_overflow = !regs_q[RI_AUC][AUC_CLIPOFF];
  assign low_half_zeroing = !regs_q[RI_AUC][AUC_ZKEEP];
  assign ptr_idx = {2'b00, cur.ptr};
  assign sf_run = exec && cur.opc == OP_SPECIAL
      && (cur.cmode == CM_ALWAYS || cond_ok(cur.tsel, flags_q, regs_q[RI_C0], regs_q[RI_C1]));
  assign counted = exec && cur.opc == OP_SPECIAL && cur.cmode == CM_IFC;

  // handshake: reads get one wait state, commands wait until their last cycle
  assign avs_waitrequest_out = (start && !fin) || (avs_read_in && !rd_pend_q);
  assign avs_readdata_out = rd_mux_q;
  // pop holds interrupts off from the decrement through the load
  assign uninterruptible_out = (go1 && cur.opc == OP_POP && !refuse)
      || state_q == ST_POP_RD || state_q == ST_POP_LD;

  // =========================================================
  // sequencer
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go1 && !one_cyc) begin
            state_q <= (cur.opc == OP_POP) ? ST_POP_RD : ST_SECOND;
          end
        end
        ST_SECOND: state_q <= ST_IDLE;
        ST_POP_RD: state_q <= ST_POP_LD;
        ST_POP_LD: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // command latch for the later cycles
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cmd_q <= '0;
    end else if (go1) begin
      cmd_q <= cur;
    end
  end

  // =========================================================
  // data memory port
  always_comb begin
    if (cur.opc == OP_DLOAD || cur.opc == OP_DSTORE) begin
      mem_addr = AW'({regs_q[RI_DP][DP_W-1:0], cur.offs});
    end else begin
      mem_addr = AW'(regs_q[ptr_idx]);
    end
  end
  assign mem_we = exec && (cur.opc == OP_STORE || cur.opc == OP_SWAP
      || cur.opc == OP_DSTORE || cur.opc == OP_PUSH);
  assign mem_wdata = regs_q[cur.rsel];

  dmsf_ymem #(.AW(AW), .DW(REG_W)) u_ymem (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .we_in(mem_we),
    .addr_in(mem_addr),
    .wdata_in(mem_wdata),
    .rdata_out(mem_rd)
  );

  // =========================================================
  // register destination of a data move
  always_comb begin
    wr_en = exec;
    case (cur.opc)
      OP_LONG: wr_val = ext_reg(cur.rsel, avs_writedata_in[15:0]);
      OP_SHORT: wr_val = short_ext(cur.rsel, cur[SHORT_W-1:0]);
      OP_ACC_RD: wr_val = ext_reg(cur.rsel, half_rd(acc_q[cur.src], cur.low, clip_on_overflow));
      OP_LOAD, OP_SWAP, OP_DLOAD, OP_POP: wr_val = ext_reg(cur.rsel, mem_rd);
      default: begin
        wr_en = 1'b0;
        wr_val = '0;
      end
    endcase
  end

  // register file; the data move result lands last so it wins over pointer updates
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= '0;
      end
    end else begin
      if (go1 && cur.opc == OP_POP && !refuse) begin
        regs_q[ptr_idx] <= regs_q[ptr_idx] - 16'h0001;
      end
      if (exec && (cur.opc == OP_LOAD || cur.opc == OP_STORE || cur.opc == OP_SWAP)) begin
        regs_q[ptr_idx] <= post_mod(regs_q[ptr_idx], cur.pmod, regs_q[RI_J]);
      end
      if (exec && cur.opc == OP_PUSH) begin
        regs_q[ptr_idx] <= regs_q[ptr_idx] + 16'h0001;
      end
      // counter zero is never touched here, and the test saw the old counter one
      if (counted) begin
        regs_q[RI_C1] <= ext_reg(RI_C1, regs_q[RI_C1] + 16'h0001);
      end
      if (counted && sf_run) begin
        regs_q[RI_C2] <= ext_reg(RI_C2, regs_q[RI_C1] + 16'h0001);
      end
      if (wr_en) begin
        regs_q[cur.rsel] <= wr_val;
        if (cur.rsel == RI_YH && low_half_zeroing) begin
          regs_q[RI_YL] <= '0;
        end
      end
    end
  end

  // =========================================================
  // accumulators and flags
  always_comb begin
    acc_we = 1'b0;
    acc_new = acc_q[cur.dst];
    if (exec && cur.opc == OP_ACC_WR) begin
      acc_we = 1'b1;
      if (cur.low) begin
        acc_new[15:0] = regs_q[cur.rsel];
      end else begin
        acc_new[35:16] = {{4{regs_q[cur.rsel][15]}}, regs_q[cur.rsel]};
        if (low_half_zeroing) begin
          acc_new[15:0] = 16'h0000;
        end
      end
    end else if (sf_run) begin
      acc_we = 1'b1;
      acc_new = sf_calc(cur.sop, acc_q[cur.src], {regs_q[RI_YH], regs_q[RI_YL]}, product_in,
                        regs_q[RI_AUC][AUC_ALIGN_LSB+1:AUC_ALIGN_LSB]);
    end
  end

  // software preloads either accumulator over the bus; a running command owns the port
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      acc_q[0] <= '0;
      acc_q[1] <= '0;
    end else if (acc_we) begin
      acc_q[cur.dst] <= acc_new;
    end else if (avs_write_in && avs_address_in == ACC0_LO_OFS) begin
      acc_q[0][31:0] <= avs_writedata_in;
    end else if (avs_write_in && avs_address_in == ACC0_GD_OFS) begin
      acc_q[0][35:32] <= avs_writedata_in[3:0];
    end else if (avs_write_in && avs_address_in == ACC1_LO_OFS) begin
      acc_q[1][31:0] <= avs_writedata_in;
    end else if (avs_write_in && avs_address_in == ACC1_GD_OFS) begin
      acc_q[1][35:32] <= avs_writedata_in[3:0];
    end
  end

  // flags follow the latest accumulator or bit-manipulation result
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      flags_q <= '0;
    end else if (acc_we) begin
      flags_q.neg <= acc_new[35];
      flags_q.zero <= (acc_new == '0);
      flags_q.ovf <= (acc_new[35:31] != 5'h00) && (acc_new[35:31] != 5'h1F);
    end else if (bmu_valid_in) begin
      flags_q.neg <= bmu_neg_in;
      flags_q.zero <= bmu_zero_in;
    end
  end

  // refused flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= (fin && refuse) || (refused_q && !(avs_write_in
          && avs_address_in == STATUS_OFS && avs_writedata_in[ST_REFUSED]));
    end
  end

  // =========================================================
  // read-back
  always_comb begin
    rd_mux = '0;
    case (avs_address_in)
      CMD_OFS: rd_mux = cmd_q;
      STATUS_OFS: begin
        rd_mux[ST_BUSY] = (state_q != ST_IDLE);
        rd_mux[ST_REFUSED] = refused_q;
        rd_mux[ST_UNINT] = uninterruptible_out;
        rd_mux[ST_FLAG_LSB+2:ST_FLAG_LSB] = flags_q;
      end
      ACC0_LO_OFS: rd_mux = acc_q[0][31:0];
      ACC0_GD_OFS: rd_mux[3:0] = acc_q[0][35:32];
      ACC1_LO_OFS: rd_mux = acc_q[1][31:0];
      ACC1_GD_OFS: rd_mux[3:0] = acc_q[1][35:32];
      default: begin
        if (avs_address_in[7:6] == REGWIN_PAGE) begin
          rd_mux[REG_W-1:0] = regs_q[avs_address_in[5:2]];
        end
      end
    endcase
  end

  // registered read data costs one wait state per read
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rd_pend_q <= 1'b0;
      rd_mux_q <= '0;
    end else begin
      rd_pend_q <= avs_read_in && !rd_pend_q;
      if (avs_read_in && !rd_pend_q) begin
        rd_mux_q <= rd_mux;
      end
    end
  end

  // =========================================================
  // assertions
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  property p_long_refused;
    go1 && cur.opc == OP_LONG && cur.in_cache |-> !avs_waitrequest_out ##1 refused_q;
  endproperty
  a_long_refused: assert property (p_long_refused) else $error("cached long load ran");

  property p_short_ext;
    go1 && cur.opc == OP_SHORT && cur.rsel <= RI_K
      |=> regs_q[$past(cur.rsel)] == short_ext($past(cur.rsel), $past(avs_writedata_in[8:0]));
  endproperty
  a_short_ext: assert property (p_short_ext) else $error("short literal wrong");

  property p_short_fast;
    go1 && cur.opc == OP_SHORT |-> !avs_waitrequest_out;
  endproperty
  a_short_fast: assert property (p_short_fast) else $error("short literal slow");

  property p_special_fast;
    go1 && cur.opc == OP_SPECIAL |-> !avs_waitrequest_out ##1 state_q == ST_IDLE;
  endproperty
  a_special_fast: assert property (p_special_fast) else $error("special op slow");

  property p_swap;
    exec && cmd_q.opc == OP_SWAP && state_q == ST_SECOND
      |-> (mem_we && mem_wdata == regs_q[cmd_q.rsel])
      ##1 regs_q[$past(cmd_q.rsel)] == ext_reg($past(cmd_q.rsel), $past(mem_rd));
  endproperty
  a_swap: assert property (p_swap) else $error("swap mismatch");

  property p_direct;
    go1 && cur.opc == OP_DLOAD |-> mem_addr == AW'({regs_q[RI_DP][10:0], cur.offs});
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");

  property p_pop_block;
    go1 && cur.opc == OP_POP |-> uninterruptible_out [*3] ##0 state_q == ST_POP_LD;
  endproperty
  a_pop_block: assert property (p_pop_block) else $error("pop interruptible");

  property p_counted;
    counted |=> regs_q[RI_C1][7:0] == $past(regs_q[RI_C1][7:0]) + 8'h01
      && regs_q[RI_C0] == $past(regs_q[RI_C0]);
  endproperty
  a_counted: assert property (p_counted) else $error("event count wrong");

  property p_guard_copy;
    exec && cur.opc == OP_ACC_WR && !cur.low |=> acc_q[$past(cur.dst)][35:32]
      == {4{acc_q[$past(cur.dst)][31]}};
  endproperty
  a_guard_copy: assert property (p_guard_copy) else $error("guards not bit 31");

  c_pop: cover property (go1 && cur.opc == OP_POP ##2 fin);
  c_counted_run: cover property (counted && sf_run);
  c_refused: cover property (fin && refuse);
endmodule

//--- hw/dmsf_ymem.sv
`timescale 1ns/10ps
// =========================================================
// data memory, one write port, registered read
module dmsf_ymem #(
  parameter int AW = 16,
  parameter int DW = 16
) (
  input logic mclk_in,
  input logic rst_n_in,
  input logic we_in,
  input logic [AW-1:0] addr_in,
  input logic [DW-1:0] wdata_in,
  output logic [DW-1:0] rdata_out
);
  logic [DW-1:0] mem_q [2**AW];

  // array itself has no reset; contents are undefined until written
  always_ff @(posedge mclk_in) begin
    if (we_in) begin
      mem_q[addr_in] <= wdata_in;
    end
  end

  // read data registered, old contents on a same-cycle write
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem_q[addr_in];
    end
  end
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import dmsf_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h00000000;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic uninterruptible_out;
  logic bmu_valid_in = 1'b0;
  logic bmu_neg_in = 1'b0;
  logic bmu_zero_in = 1'b0;
  logic [31:0] product_in = 32'h9ABCDEF0;
  logic saw_unint = 1'b0;
  logic [31:0] q;
  logic [35:0] v;
  logic [35:0] w;
  int bad_count = 0;
  int checks_done = 0;
  // =========================================================
  // clock; the flag catches the pop lock-out, which lasts only a few cycles
  initial forever #4 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (uninterruptible_out === 1'b1) saw_unint <= 1'b1;
  dmsf_unit dmsf_unit_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .product_in(product_in),
    .bmu_valid_in(bmu_valid_in), .bmu_neg_in(bmu_neg_in), .bmu_zero_in(bmu_zero_in),
    .uninterruptible_out(uninterruptible_out));
  // =========================================================
  // reporting
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus cycle; the request stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    avs_writedata_in <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (n == 50) begin
      chk(36'h1, 36'h0);
      end_of_test;
    end
  endtask
  task rreg(input logic [3:0] i);
    bus(1'b0, {2'b01, i, 2'b00}, 32'h0);
  endtask
  task racc(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    v[31:0] = q;
    bus(1'b0, a + 8'h04, 32'h0);
    v[35:32] = q[3:0];
  endtask
  function automatic logic [31:0] sf(input logic [3:0] s, input logic [1:0] m,
                                     input logic [3:0] t);
    return {OP_SPECIAL, 4'h0, m, t, 2'b10, s, 2'b10, 10'h000};
  endfunction
  // expected special result; shifts by 1, 4, 8, 16 from the low two op bits
  function automatic logic [35:0] fx(input logic [3:0] s, input logic [35:0] a);
    int k;
    logic [31:0] l;
    k = (s[1:0] == 2'h0) ? 1 : (s[1:0] == 2'h1) ? 4 : (s[1:0] == 2'h2) ? 8 : 16;
    l = a[31:0] << k;
    if (s < 4'h4) return $unsigned($signed(a) >>> k);
    if (s >= 4'hC) return {{4{l[31]}}, l};
    case (s)
      4'h4: return a;
      4'h5: return -a;
      4'h6: return ~a;
      4'h7: return (a + RND_BIAS) & 36'hFFFFF0000;
      4'h8: return (a + INCH_ADD) & 36'hFFFFF0000;
      4'h9: return a + INC_ADD;
      4'hA: return 36'h0;
      default: return {{4{product_in[31]}}, product_in};
    endcase
  endfunction
  // =========================================================
  // scenarios
  task t_moves;
    bus(1'b1, CMD_OFS, {OP_SHORT, RI_J, 8'h02, 16'hF1F0});
    bus(1'b1, CMD_OFS, {OP_SHORT, 4'h0, 8'h02, 16'hF00D});
    rreg(RI_J);
    chk(q, 36'hFFF0);
    rreg(4'h0);
    chk(q, 36'h000D);
    bus(1'b1, CMD_OFS, {OP_LONG, 4'h1, 8'h02, 16'hABCD});
    bus(1'b0, STATUS_OFS, 32'h0);
    chk(q[ST_REFUSED], 36'h1);
    bus(1'b1, STATUS_OFS, 32'h2);
    bus(1'b1, CMD_OFS, {OP_LONG, 4'h1, 8'h00, 16'hABCD});
    rreg(4'h1);
    chk(q, 36'hABCD);
    $display("moves done");
  endtask
  // a one-cycle pulse from the bit unit sets the sign flag that the next test sees
  task flag_run(input logic n, input logic [35:0] e);
    @(posedge mclk_in);
    bmu_neg_in <= n;
    bmu_valid_in <= 1'b1;
    @(posedge mclk_in);
    bmu_valid_in <= 1'b0;
    bus(1'b1, CMD_OFS, sf(SOP_NOT, 2'h1, {TB_MI, 1'b0}));
    racc(ACC1_LO_OFS);
    chk(v, e);
  endtask
  task t_special;
    w = 36'h812349678;
    bus(1'b1, ACC0_LO_OFS, w[31:0]);
    bus(1'b1, ACC0_GD_OFS, {28'h0, w[35:32]});
    bus(1'b1, CMD_OFS, {OP_ACC_RD, RI_RB, 8'h00, 16'h0000});
    rreg(RI_RB);
    chk(q, CLIP_NEG_HI);
    for (int s = 0; s < 16; s++) begin
      bus(1'b1, CMD_OFS, sf(s[3:0], CM_ALWAYS, 4'h0));
      racc(ACC1_LO_OFS);
      chk(v, fx(s[3:0], w));
    end
    bus(1'b1, CMD_OFS, sf(SOP_INC, 2'h2, {TB_TRUE, 1'b1}));
    racc(ACC1_LO_OFS);
    chk(v, fx(4'hF, w));
    bus(1'b1, CMD_OFS, sf(SOP_INC, 2'h2, {TB_TRUE, 1'b0}));
    racc(ACC1_LO_OFS);
    chk(v, w + 36'h1);
    bus(1'b1, CMD_OFS, sf(SOP_COPY, 2'h2, {TB_C0LT, 1'b1}));
    racc(ACC1_LO_OFS);
    chk(v, w);
    rreg(RI_C1);
    chk(q, 36'h3);
    rreg(RI_C2);
    chk(q, 36'h3);
    rreg(RI_C0);
    chk(q, 36'h0);
    flag_run(1'b0, w);
    flag_run(1'b1, ~w);
    $display("special done");
  endtask
  task t_stack;
    bus(1'b1, CMD_OFS, {OP_ACC_WR, RI_J, 8'h00, 16'h0000});
    racc(ACC0_LO_OFS);
    chk(v, 36'hFFFF00000);
    bus(1'b1, CMD_OFS, {OP_SHORT, 4'h2, 8'h02, 16'h0010});
    bus(1'b1, CMD_OFS, {OP_PUSH, RI_J, 8'h00, 7'h00, 2'h2, 7'h00});
    rreg(4'h2);
    chk(q, 36'h0011);
    bus(1'b1, CMD_OFS, {OP_POP, RI_K, 8'h00, 7'h00, 2'h2, 7'h00});
    rreg(4'h2);
    chk(q, 36'h0010);
    rreg(RI_K);
    chk(q, 36'hFFF0);
    chk({saw_unint, uninterruptible_out}, 36'h2);
    bus(1'b1, CMD_OFS, {OP_SWAP, RI_RB, 8'h00, 7'h00, 2'h2, 7'h00});
    rreg(RI_RB);
    chk(q, 36'hFFF0);
    bus(1'b1, CMD_OFS, {OP_DLOAD, RI_RE, 8'h00, 11'h000, 5'h10});
    rreg(RI_RE);
    chk(q, 36'h8000);
    $display("stack done");
  endtask
  initial begin
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_moves;
    t_special;
    t_stack;
    end_of_test;
  end
endmodule
